// *** hw/dpi_device.sv ***
/*
  Device-side command, address and data-strobe pin interface of a DDR memory,
  with mode registers and status reachable over classic Wishbone.
  Assumes all pins come from the link clock domain and are resampled here;
  the link clock is much slower than clk_i (several clk_i per half period).
*/
// Our own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
`include "dpi_regs.svh"

module dpi_device #(
  parameter int DQ_W = 8,
  parameter int COL_W = 6
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire dpi_pkg::dpi_pins_t pins_i,
  input wire dpi_pkg::dpi_wb_req_t wb_i,
  output logic [7:0] dq_o,
  output logic [7:0] dq_oe_o,
  output logic dqs_o,
  output logic dqs_oe_o,
  output logic term_en_o,
  output logic tstrobe_en_o,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o
);
  import dpi_pkg::*;

  localparam int AW = 3 + COL_W;

  if (!(DQ_W == 4 || DQ_W == 8) || COL_W < 3 || COL_W > 12)
  begin : g_bad_param
    $error("dpi_device: DQ_W must be 4 or 8, COL_W 3 to 12");
  end

  typedef struct packed {
    logic link_d;
    logic dqs_d;
    dpi_pwr_t ps;
    logic [7:0] open;
    logic [3:0][14:0] mr;
    logic [3:0] rd_lat;
    logic dec_en;
    logic wr_act;
    logic wr_chop;
    logic [3:0] wr_cnt;
    logic [AW-1:0] wr_base;
    logic rd_act;
    logic rd_chop;
    logic [3:0] rd_wait;
    logic [3:0] rd_cnt;
    logic [AW-1:0] rd_base;
    logic beat_q;
    logic beat_odd;
    logic [7:0] dq;
    logic [7:0] dq_oe;
    logic dqs;
    logic dqs_oe;
    logic term;
    logic tstrobe;
    logic ack;
    logic [31:0] dat;
    logic st_we;
    logic [AW-1:0] st_wa;
    logic [7:0] st_wd;
    logic [AW-1:0] st_ra;
  } dpi_state_t;

  localparam dpi_state_t ST_RST = '{
    ps: PS_ACTIVE,
    rd_lat: `DPI_CTRL_LAT_RST,
    dec_en: `DPI_CTRL_DEC_RST,
    default: '0
  };

  localparam logic [7:0] LANES = (DQ_W == 8) ? 8'hFF : 8'h0F;

  dpi_state_t s_reg;
  dpi_state_t s_next;
  dpi_pins_t p;
  dpi_cmd_t cmd;
  logic [7:0] st_rd;
  logic link_rise;
  logic link_edge;
  logic dqs_edge;
  logic fire;
  logic chop;
  logic tstrobe_on;

  dpi_sync #(
    .W($bits(dpi_pins_t))
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i(pins_i),
    .q_o(p)
  );

  dpi_store #(
    .AW(AW),
    .DW(8)
  ) u_store (
    .clk_i(clk_i),
    .ce_i(ce_i),
    .we_i(s_reg.st_we),
    .wa_i(s_reg.st_wa),
    .wd_i(s_reg.st_wd),
    .ra_i(s_reg.st_ra),
    .rd_o(st_rd)
  );

  assign link_rise = p.link_clk & ~s_reg.link_d;
  assign link_edge = p.link_clk ^ s_reg.link_d;
  assign dqs_edge = p.dqs ^ s_reg.dqs_d;
  assign cmd = dpi_cmd_t'({p.ras_n, p.cas_n, p.we_n});
  // Decoder runs only while powered up, selected and enabled
  assign fire = link_rise && s_reg.ps == PS_ACTIVE && p.cke && !p.cs_n && s_reg.dec_en;
  assign tstrobe_on = (DQ_W == 8) && s_reg.mr[1][`DPI_MODE1_TSTROBE_BIT];
  always_comb
  begin
    case (s_reg.mr[0][`DPI_MODE0_BL_MSB:`DPI_MODE0_BL_LSB])
      `DPI_BL_OTF: chop = !p.addr[`DPI_CHOP_SEL_BIT];
      `DPI_BL_FIXED4: chop = 1'h1;
      default: chop = 1'h0;
    endcase
  end

  always_comb
  begin
    dpi_state_t keep;
    logic [31:0] stat;
    keep = '0;
    stat = '0;
    s_next = s_reg;
    s_next.link_d = p.link_clk;
    s_next.dqs_d = p.dqs;
    s_next.st_we = 1'h0;
    s_next.beat_q = 1'h0;
    s_next.ack = 1'h0;

    // Wishbone slave: one wait state, ack dropped after one cycle
    stat[`DPI_ST_PS_LSB +: 2] = s_reg.ps;
    stat[`DPI_ST_TERM_BIT] = s_reg.term;
    stat[`DPI_ST_WR_BIT] = s_reg.wr_act;
    stat[`DPI_ST_RD_BIT] = s_reg.rd_act;
    stat[`DPI_ST_TSTROBE_BIT] = s_reg.tstrobe;
    stat[`DPI_ST_OPEN_LSB +: 8] = s_reg.open;
    if (wb_i.cyc && wb_i.stb && !s_reg.ack)
    begin
      s_next.ack = 1'h1;
      case (wb_i.adr)
        `DPI_MODE0_OFS: s_next.dat = {17'h0, s_reg.mr[0]};
        `DPI_MODE1_OFS: s_next.dat = {17'h0, s_reg.mr[1]};
        `DPI_MODE2_OFS: s_next.dat = {17'h0, s_reg.mr[2]};
        `DPI_MODE3_OFS: s_next.dat = {17'h0, s_reg.mr[3]};
        `DPI_STATUS_OFS: s_next.dat = stat;
        `DPI_CTRL_OFS:
        begin
          s_next.dat = '0;
          s_next.dat[`DPI_CTRL_LAT_MSB:`DPI_CTRL_LAT_LSB] = s_reg.rd_lat;
          s_next.dat[`DPI_CTRL_DEC_BIT] = s_reg.dec_en;
          if (wb_i.we && wb_i.sel[0])
            s_next.rd_lat = wb_i.dat[`DPI_CTRL_LAT_MSB:`DPI_CTRL_LAT_LSB];
          if (wb_i.we && wb_i.sel[1])
            s_next.dec_en = wb_i.dat[`DPI_CTRL_DEC_BIT];
        end
        default: s_next.dat = '0;
      endcase
      // Write cycles return zero data
      if (wb_i.we)
        s_next.dat = '0;
    end

    // Power states
    case (s_reg.ps)
      PS_ACTIVE:
      begin
        if (link_rise && !p.cke)
        begin
          if (s_reg.open != 8'h00)
            s_next.ps = PS_ACT_PD;
          else if (!p.cs_n && cmd == CMD_REF)
            s_next.ps = PS_SELF;
          else
            s_next.ps = PS_PRE_PD;
        end
      end
      PS_PRE_PD, PS_ACT_PD:
      begin
        if (link_rise && p.cke)
          s_next.ps = PS_ACTIVE;
      end
      PS_SELF:
      begin
        // Exit needs no link clock edge
        if (p.cke)
          s_next.ps = PS_ACTIVE;
      end
      default: s_next.ps = PS_ACTIVE;
    endcase

    // Write beats on every strobe edge, centred in the data eye
    if (s_reg.wr_act && dqs_edge && !s_reg.dqs_oe)
    begin
      s_next.wr_cnt = s_reg.wr_cnt + 4'h1;
      if (!p.write_mask || tstrobe_on)
      begin
        s_next.st_we = 1'h1;
        s_next.st_wa = {s_reg.wr_base[AW-1:3], s_reg.wr_base[2:0] + s_reg.wr_cnt[2:0]};
        s_next.st_wd = p.dq & LANES;
      end
      if (s_next.wr_cnt == (s_reg.wr_chop ? `DPI_BURST4 : `DPI_BURST8))
        s_next.wr_act = 1'h0;
    end

    // Read beats issued on both link clock edges after the latency
    if (s_reg.rd_act && link_edge)
    begin
      if (s_reg.rd_wait != 4'h0)
        s_next.rd_wait = s_reg.rd_wait - 4'h1;
      else if (s_reg.rd_cnt == (s_reg.rd_chop ? `DPI_BURST4 : `DPI_BURST8))
      begin
        s_next.rd_act = 1'h0;
        s_next.dq_oe = 8'h00;
        s_next.dqs_oe = 1'h0;
      end
      else
      begin
        s_next.st_ra = {s_reg.rd_base[AW-1:3], s_reg.rd_base[2:0] + s_reg.rd_cnt[2:0]};
        s_next.beat_q = 1'h1;
        s_next.beat_odd = s_reg.rd_cnt[0];
        s_next.rd_cnt = s_reg.rd_cnt + 4'h1;
      end
    end
    // Strobe changes in the same cycle as the data
    if (s_reg.beat_q)
    begin
      s_next.dq = st_rd & LANES;
      s_next.dq_oe = LANES;
      s_next.dqs = ~s_reg.beat_odd;
      s_next.dqs_oe = 1'h1;
    end

    // Commands; a new read or write overrides a burst of its own kind still running
    if (fire)
    begin
      case (cmd)
        CMD_MRS: s_next.mr[p.ba[1:0]] = p.addr;
        CMD_ACT: s_next.open[p.ba] = 1'h1;
        CMD_PRE:
        begin
          if (p.addr[`DPI_AUTOPRE_BIT])
            s_next.open = 8'h00;
          else
            s_next.open[p.ba] = 1'h0;
        end
        CMD_WR:
        begin
          s_next.wr_act = 1'h1;
          s_next.wr_cnt = 4'h0;
          s_next.wr_chop = chop;
          s_next.wr_base = {p.ba, p.addr[COL_W-1:0]};
          if (p.addr[`DPI_AUTOPRE_BIT])
            s_next.open[p.ba] = 1'h0;
        end
        CMD_RD:
        begin
          s_next.rd_act = 1'h1;
          s_next.rd_cnt = 4'h0;
          s_next.rd_wait = s_reg.rd_lat;
          s_next.rd_chop = chop;
          s_next.rd_base = {p.ba, p.addr[COL_W-1:0]};
          if (p.addr[`DPI_AUTOPRE_BIT])
            s_next.open[p.ba] = 1'h0;
        end
        default: ;
      endcase
    end

    // Termination input is dead in self refresh
    s_next.term = p.on_die_termination && s_reg.mr[1][`DPI_MODE1_TERM_BIT]
      && s_reg.ps != PS_SELF;
    s_next.tstrobe = tstrobe_on;

    // Pin reset clears the device but not the bus-side registers
    if (!p.reset_n)
    begin
      keep = s_next;
      s_next = ST_RST;
      s_next.link_d = keep.link_d;
      s_next.dqs_d = keep.dqs_d;
      s_next.ack = keep.ack;
      s_next.dat = keep.dat;
      s_next.rd_lat = keep.rd_lat;
      s_next.dec_en = keep.dec_en;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_reg <= ST_RST;
    else if (ce_i)
      s_reg <= s_next;
  end

  assign dq_o = s_reg.dq;
  assign dq_oe_o = s_reg.dq_oe;
  assign dqs_o = s_reg.dqs;
  assign dqs_oe_o = s_reg.dqs_oe;
  assign term_en_o = s_reg.term;
  assign tstrobe_en_o = s_reg.tstrobe;
  assign wb_ack_o = s_reg.ack;
  assign wb_dat_o = s_reg.dat;

  default clocking cb @(posedge clk_i iff ce_i);
  endclocking
  default disable iff (rst_i);

  property p_pre_all;
    fire && cmd == CMD_PRE && p.addr[`DPI_AUTOPRE_BIT] && p.reset_n |=> s_reg.open == 8'h00;
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("all-bank precharge left a row open");

  property p_pre_one;
    fire && cmd == CMD_PRE && !p.addr[`DPI_AUTOPRE_BIT] && p.reset_n
      |=> s_reg.open == ($past(s_reg.open) & ~(8'h01 << $past(p.ba)));
  endproperty
  a_pre_one: assert property (p_pre_one) else $error("single-bank precharge hit wrong banks");

  property p_mode_load;
    fire && cmd == CMD_MRS && p.reset_n |=> s_reg.mr[$past(p.ba[1:0])] == $past(p.addr);
  endproperty
  a_mode_load: assert property (p_mode_load) else $error("mode register not loaded");

  property p_cs_mask;
    link_rise && p.cs_n && p.cke && p.reset_n && s_reg.ps == PS_ACTIVE
      |=> $stable(s_reg.open) && $stable(s_reg.mr);
  endproperty
  a_cs_mask: assert property (p_cs_mask) else $error("deselected command took effect");

  property p_act_pd;
    link_rise && !p.cke && p.reset_n && s_reg.ps == PS_ACTIVE && s_reg.open != 8'h00
      |=> s_reg.ps == PS_ACT_PD;
  endproperty
  a_act_pd: assert property (p_act_pd) else $error("open row did not give active power-down");

  property p_self_exit;
    s_reg.ps == PS_SELF && p.cke && p.reset_n |=> s_reg.ps == PS_ACTIVE;
  endproperty
  a_self_exit: assert property (p_self_exit) else $error("self refresh exit delayed");

  property p_mask;
    s_reg.wr_act && dqs_edge && !s_reg.dqs_oe && p.write_mask && !tstrobe_on |=> !s_reg.st_we;
  endproperty
  a_mask: assert property (p_mask) else $error("masked beat was written");

  property p_term;
    term_en_o |-> $past(s_reg.mr[1][`DPI_MODE1_TERM_BIT]) && $past(s_reg.ps) != PS_SELF;
  endproperty
  a_term: assert property (p_term) else $error("termination on while disabled");

  property p_narrow;
    DQ_W == 4 |-> dq_oe_o[7:4] == 4'h0 && !tstrobe_en_o;
  endproperty
  a_narrow: assert property (p_narrow) else $error("upper lanes used in by-four");

  property p_chop;
    fire && cmd == CMD_WR && p.reset_n
      && s_reg.mr[0][`DPI_MODE0_BL_MSB:`DPI_MODE0_BL_LSB] == `DPI_BL_OTF
      |=> s_reg.wr_chop == !$past(p.addr[`DPI_CHOP_SEL_BIT]);
  endproperty
  a_chop: assert property (p_chop) else $error("burst chop select misread");

endmodule : dpi_device

`default_nettype wire

// *** hw/dpi_pkg.sv ***
/*
  Types of the command/address pin interface: command codes, power states
  and the carriers for pins and Wishbone requests. Assumes nothing else.
*/
package dpi_pkg;

  // Row, column and write strobes, all active low
  typedef enum logic [2:0] {
    CMD_MRS = 3'h0,
    CMD_REF = 3'h1,
    CMD_PRE = 3'h2,
    CMD_ACT = 3'h3,
    CMD_WR = 3'h4,
    CMD_RD = 3'h5,
    CMD_ZQ = 3'h6,
    CMD_NOP = 3'h7
  } dpi_cmd_t;

  typedef enum logic [1:0] {
    PS_ACTIVE = 2'h0,
    PS_PRE_PD = 2'h1,
    PS_ACT_PD = 2'h2,
    PS_SELF = 2'h3
  } dpi_pwr_t;

  typedef struct packed {
    logic link_clk;
    logic cke;
    logic reset_n;
    logic on_die_termination;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] ba;
    logic [14:0] addr;
    logic write_mask;
    logic [7:0] dq;
    logic dqs;
  } dpi_pins_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } dpi_wb_req_t;

endpackage : dpi_pkg

// *** hw/dpi_regs.svh ***
/*
  Register offsets, field positions, reset values and burst counts of the
  command/address pin interface. Assumes inclusion by bare name from hw/.
*/
`ifndef DPI_REGS_SVH
`define DPI_REGS_SVH

`define DPI_MODE0_OFS 8'h00
`define DPI_MODE1_OFS 8'h04
`define DPI_MODE2_OFS 8'h08
`define DPI_MODE3_OFS 8'h0C
`define DPI_STATUS_OFS 8'h10
`define DPI_CTRL_OFS 8'h14

`define DPI_MODE0_BL_LSB 0
`define DPI_MODE0_BL_MSB 1
`define DPI_BL_FIXED8 2'h0
`define DPI_BL_OTF 2'h1
`define DPI_BL_FIXED4 2'h2
`define DPI_MODE1_TERM_BIT 2
`define DPI_MODE1_TSTROBE_BIT 11

`define DPI_AUTOPRE_BIT 10
`define DPI_CHOP_SEL_BIT 12

`define DPI_CTRL_LAT_LSB 0
`define DPI_CTRL_LAT_MSB 3
`define DPI_CTRL_DEC_BIT 8
`define DPI_CTRL_LAT_RST 4'h4
`define DPI_CTRL_DEC_RST 1'h1

`define DPI_ST_PS_LSB 0
`define DPI_ST_TERM_BIT 4
`define DPI_ST_WR_BIT 5
`define DPI_ST_RD_BIT 6
`define DPI_ST_TSTROBE_BIT 7
`define DPI_ST_OPEN_LSB 8

`define DPI_BURST8 4'h8
`define DPI_BURST4 4'h4

`endif

// *** hw/dpi_store.sv ***
/*
  Small data array behind the pin interface: one write port, one
  combinational read port. Contents are not cleared by any reset.
*/
`timescale 1ns/10ps
`default_nettype none

module dpi_store #(
  parameter int AW = 9,
  parameter int DW = 8
) (
  input wire logic clk_i,
  input wire logic ce_i,
  input wire logic we_i,
  input wire logic [AW-1:0] wa_i,
  input wire logic [DW-1:0] wd_i,
  input wire logic [AW-1:0] ra_i,
  output logic [DW-1:0] rd_o
);
  logic [DW-1:0] mem [2**AW];

  if (AW < 1 || AW > 16 || DW < 1)
  begin : g_bad_size
    $error("dpi_store: unsupported size");
  end

  always_ff @(posedge clk_i)
  begin
    if (ce_i && we_i)
      mem[wa_i] <= wd_i;
  end

  assign rd_o = mem[ra_i];

endmodule : dpi_store

`default_nettype wire

// *** hw/dpi_sync.sv ***
/*
  Two-stage synchroniser for a bundle of pin levels.
  Assumes the bundle is stable long enough for every bit to be caught.
*/
`timescale 1ns/10ps
`default_nettype none

module dpi_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } dpi_sync_t;

  dpi_sync_t s_reg;
  dpi_sync_t s_next;

  if (W < 1)
  begin : g_bad_w
    $error("dpi_sync: width must be at least one");
  end

  // First stage feeds only the second
  always_comb
  begin
    s_next.meta = d_i;
    s_next.sync = s_reg.meta;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_reg <= '0;
    else if (ce_i)
      s_reg <= s_next;
  end

  assign q_o = s_reg.sync;

endmodule : dpi_sync

`default_nettype wire

// *** tb/dpi_ctl_model.sv ***
/*
  Controller-side pin model: framed commands and write bursts.
  Assumes clk_i at 4 ns; the 52 ns link clock runs only inside frames.
*/
`timescale 1ns/10ps
`default_nettype none

module dpi_ctl_model (
  input wire logic clk_i,
  output logic [35:0] pins_o
);
  import dpi_pkg::*;
  dpi_pins_t p;
  logic drv;
  assign pins_o = p;
  initial
  begin
    drv = 1'b0;
    p = '0;
    p.reset_n = 1'b1;
    p.cke = 1'b1;
    p.cs_n = 1'b1;
    {p.ras_n, p.cas_n, p.we_n} = CMD_NOP;
  end
  // Released lines toggle so a stale value never looks valid
  always @(posedge clk_i)
    if (!drv)
    begin
      p.dq <= ~p.dq;
      p.dqs <= ~p.dqs;
    end
  task automatic lvl(input logic cke, input logic rst_n, input logic term);
    @(posedge clk_i);
    p.cke <= cke;
    p.reset_n <= rst_n;
    p.on_die_termination <= term;
  endtask : lvl
  // Pins settle 6 cycles before and hold 6 after the rising link edge
  task automatic cmd(input dpi_cmd_t c, input logic cs_n, input logic [2:0] ba,
                     input logic [14:0] a);
    @(posedge clk_i);
    p.cs_n <= cs_n;
    {p.ras_n, p.cas_n, p.we_n} <= c;
    p.ba <= ba;
    p.addr <= a;
    repeat (6) @(posedge clk_i);
    p.link_clk <= 1'b1;
    repeat (6) @(posedge clk_i);
    p.link_clk <= 1'b0;
  endtask : cmd
  task automatic wr(input logic [2:0] ba, input logic [7:0] d0, input int mb);
    drv = 1'b1;
    cmd(CMD_WR, 1'b0, ba, 15'h1000);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_i);
      p.dq <= d0 + 8'(i);
      p.write_mask <= (i == mb);
      repeat (3) @(posedge clk_i);
      p.dqs <= ~p.dqs;
      repeat (3) @(posedge clk_i);
    end
    @(posedge clk_i);
    p.write_mask <= 1'b0;
    drv = 1'b0;
  endtask : wr
endmodule : dpi_ctl_model

`default_nettype wire

// *** tb/testbench.sv ***
/*
  Bench: Wishbone tasks, pin commands through the controller model, read beat monitor.
  Assumes the device at default parameters and clk_i at 4 ns.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dpi_regs.svh"

module testbench;
  import dpi_pkg::*;
  logic clk_i, rst_i, dqs_o, dqs_oe_o, term_en_o, tstrobe_en_o, wb_ack_o, prev_dqs;
  logic [35:0] mraw;
  dpi_pins_t mpins, pins;
  dpi_wb_req_t wb;
  logic [7:0] dq_o, dq_oe_o;
  logic [31:0] wb_dat_o, q;
  logic [7:0] beats[$];
  logic [14:0] mv[4] = '{15'h0001, 15'h0004, 15'h0123, 15'h7ABC};
  int num_errors = 0;
  int n_tests = 0;
  assign mpins = mraw;
  // Wire level from the device's enables; the model's value wherever they are off
  always_comb
  begin
    pins = mpins;
    pins.dq = (dq_oe_o & dq_o) | (~dq_oe_o & mpins.dq);
    pins.dqs = dqs_oe_o ? dqs_o : mpins.dqs;
  end
  dpi_ctl_model mp (.clk_i(clk_i), .pins_o(mraw));
  dpi_device dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .pins_i(pins), .wb_i(wb),
    .dq_o(dq_o), .dq_oe_o(dq_oe_o), .dqs_o(dqs_o), .dqs_oe_o(dqs_oe_o),
    .term_en_o(term_en_o), .tstrobe_en_o(tstrobe_en_o), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o));
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask : chk
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    @(posedge clk_i);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: s, dat: d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb <= '0;
  endtask : xfer
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    xfer(1'b0, a, 32'h0, 4'hF);
    chk(n, e, q);
  endtask : rd
  // Status without the termination bit and the transient burst bits
  task automatic st(input logic [31:0] e);
    xfer(1'b0, `DPI_STATUS_OFS, 32'h0, 4'hF);
    chk("status", e, q & 32'hFF83);
  endtask : st
  // Each beat flips the strobe, so a change of level marks a new beat
  always @(posedge clk_i)
  begin
    if (dqs_oe_o === 1'b1 && dqs_o !== prev_dqs)
    begin
      beats.push_back(dq_o);
      chk("dq_oe", 32'hFF, dq_oe_o);
    end
    prev_dqs <= (dqs_oe_o === 1'b1) ? dqs_o : 1'b0;
  end
  task automatic rdb(input logic a12, input int n, input logic [7:0] b0, input int keep);
    beats.delete();
    mp.cmd(CMD_RD, 1'b0, 3'h1, {2'h0, a12, 12'h000});
    repeat (9) mp.cmd(CMD_NOP, 1'b0, 3'h0, 15'h0000);
    chk("beats", n, beats.size());
    foreach (beats[i]) chk("beat", (i == keep) ? 8'hA0 + i : b0 + i, beats[i]);
  endtask : rdb
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (30000) @(posedge clk_i);
    num_errors++;
    report_and_stop();
  end
  initial
  begin
    rst_i = 1'b1;
    wb = '0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`DPI_CTRL_OFS, 32'h104, "ctrl");
    st(32'h0);
    rd(8'h20, 32'h0, "unmapped");
    for (int i = 0; i < 4; i++) mp.cmd(CMD_MRS, 1'b0, 3'(i), mv[i]);
    mp.cmd(CMD_MRS, 1'b1, 3'h2, 15'h0055);
    xfer(1'b1, `DPI_MODE0_OFS, 32'hFFFF, 4'hF);
    for (int i = 0; i < 4; i++) rd(8'(4 * i), {17'h0, mv[i]}, "mode_reg");
    mp.lvl(1'b1, 1'b1, 1'b1);
    mp.cmd(CMD_ACT, 1'b0, 3'h1, 15'h0ABC);
    mp.cmd(CMD_ACT, 1'b0, 3'h3, 15'h0123);
    chk("term", 32'h1, term_en_o);
    st(32'h0A00);
    mp.cmd(CMD_PRE, 1'b0, 3'h3, 15'h0000);
    st(32'h0200);
    mp.wr(3'h1, 8'hA0, 8);
    mp.wr(3'h1, 8'hB0, 2);
    rdb(1'b1, 8, 8'hB0, 2);
    mp.cmd(CMD_MRS, 1'b0, 3'h1, 15'h0804);
    chk("tstrobe", 32'h1, tstrobe_en_o);
    mp.wr(3'h1, 8'hC0, 2);
    rdb(1'b1, 8, 8'hC0, 8);
    rdb(1'b0, 4, 8'hC0, 8);
    mp.cmd(CMD_PRE, 1'b0, 3'h0, 15'h0400);
    st(32'h0080);
    mp.lvl(1'b0, 1'b1, 1'b1);
    mp.cmd(CMD_NOP, 1'b0, 3'h0, 15'h0000);
    st(32'h0081);
    mp.cmd(CMD_MRS, 1'b0, 3'h2, 15'h0055);
    mp.lvl(1'b1, 1'b1, 1'b1);
    mp.cmd(CMD_NOP, 1'b0, 3'h0, 15'h0000);
    rd(`DPI_MODE2_OFS, 32'h0123, "mode_reg_2");
    mp.cmd(CMD_ACT, 1'b0, 3'h5, 15'h0000);
    mp.lvl(1'b0, 1'b1, 1'b1);
    mp.cmd(CMD_NOP, 1'b0, 3'h0, 15'h0000);
    st(32'h2082);
    mp.lvl(1'b1, 1'b1, 1'b1);
    mp.cmd(CMD_NOP, 1'b0, 3'h0, 15'h0000);
    mp.cmd(CMD_PRE, 1'b0, 3'h0, 15'h0400);
    mp.lvl(1'b0, 1'b1, 1'b1);
    mp.cmd(CMD_REF, 1'b0, 3'h0, 15'h0000);
    st(32'h0083);
    chk("term", 32'h0, term_en_o);
    mp.lvl(1'b1, 1'b1, 1'b1);
    repeat (4) @(posedge clk_i);
    st(32'h0080);
    xfer(1'b1, `DPI_CTRL_OFS, 32'h5, 4'h1);
    rd(`DPI_CTRL_OFS, 32'h105, "ctrl");
    mp.lvl(1'b1, 1'b0, 1'b1);
    repeat (6) @(posedge clk_i);
    mp.lvl(1'b1, 1'b1, 1'b1);
    repeat (4) @(posedge clk_i);
    rd(`DPI_MODE1_OFS, 32'h0, "mode_reg_1");
    rd(`DPI_CTRL_OFS, 32'h105, "ctrl");
    chk("term", 32'h0, term_en_o);
    report_and_stop();
  end
endmodule : testbench

`default_nettype wire
